// ---- hw/rx_backplane_output_config.v ----
// Receive backplane output configuration, unframed pattern generator and identifier pin remap
//
// Our own choices: the plain strobed port and the address map.
`include "rx_backplane_map.vh"
`default_nettype none
module rx_backplane_output_config (
   input wire clk,
   input wire rst_n,
   input wire [11:0] addr,
   input wire [7:0] wrData,
   input wire wrEn,
   input wire rdEn,
   output reg [7:0] rdData,
   input wire lineClockIn,
   input wire frameSyncIn,
   input wire rxDataIn,
   input wire txDataIn,
   input wire signalingIn,
   output reg txLineOut,
   output reg rxSerialClock,
   output reg rxTimeslotClock,
   output reg [4:0] timeslotIdentifierPins,
   output wire rxSerialData,
   output wire rxSerialValid,
   input wire backplaneReady,
   output wire rxAcceptReady
);
   reg [7:0] patternCtrl_reg;
   reg [7:0] rxIfCtrl_reg;
   reg overrun_reg;
   reg [2:0] clkSync_reg;
   reg [1:0] fsSync_reg;
   reg [1:0] rxSync_reg;
   reg [1:0] txSync_reg;
   reg [1:0] sigSync_reg;
   reg [7:0] bitCount_reg;
   reg [7:0] bitCount_next;
   reg [14:0] prbs_reg;
   reg [19:0] qrts_reg;
   reg rxBit_reg;
   reg [4:0] pins_next;
   reg fracData_reg;
   wire linkLevel;
   wire linkRise;
   wire unframedActive;
   wire patternSwitch;
   wire patternBit;
   wire highSpeed;
   wire fracEnable;
   wire fracSelect;
   wire gappedEnable;
   wire [4:0] slot;
   wire [2:0] slotBit;
   wire overhead;
   wire rxMuxBit;
   wire serialIdBit;
   wire fifoInReady;

   // Next value of a maximal-length register advanced by one bit
   function [14:0] prbsStep;
      input [14:0] s;
      begin
         prbsStep = {s[13:0], s[14] ^ s[13]};
      end
   endfunction

   // Bit of the current slot number sent serially, MSB first
   function serialSlotBit;
      input [4:0] s;
      input [2:0] idx;
      begin
         case (idx)
            3'h0: serialSlotBit = s[4];
            3'h1: serialSlotBit = s[3];
            3'h2: serialSlotBit = s[2];
            3'h3: serialSlotBit = s[1];
            3'h4: serialSlotBit = s[0];
            default: serialSlotBit = 1'b0;
         endcase
      end
   endfunction

   // Register fields steering the logic
   assign unframedActive = ~patternCtrl_reg[`UNFRAMED_BIT];
   assign patternSwitch = patternCtrl_reg[`PATTERN_SWITCH_BIT];
   assign fracSelect = rxIfCtrl_reg[`FRACTIONAL_CLOCK_SELECT_BIT];
   assign gappedEnable = rxIfCtrl_reg[`GAPPED_CLOCK_BIT];
   assign fracEnable = rxIfCtrl_reg[`FRACTIONAL_ENABLE_BIT];
   // Multiplexed or any non-base interface speed counts as high speed
   assign highSpeed = rxIfCtrl_reg[`MUX_ENABLE_BIT] | (rxIfCtrl_reg[1:0] != 2'h0);

   // Frame position
   assign slot = bitCount_reg[7:3];
   assign slotBit = bitCount_reg[2:0];
   assign overhead = (slot == `OVERHEAD_SLOT);

   // Line clock synchroniser; third stage only feeds edge detection
   assign linkLevel = clkSync_reg[1];
   assign linkRise = clkSync_reg[1] & ~clkSync_reg[2];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clkSync_reg <= 3'h0;
         fsSync_reg <= 2'h0;
         rxSync_reg <= 2'h0;
         txSync_reg <= 2'h0;
         sigSync_reg <= 2'h0;
      end else begin
         clkSync_reg <= {clkSync_reg[1:0], lineClockIn};
         fsSync_reg <= {fsSync_reg[0], frameSyncIn};
         rxSync_reg <= {rxSync_reg[0], rxDataIn};
         txSync_reg <= {txSync_reg[0], txDataIn};
         sigSync_reg <= {sigSync_reg[0], signalingIn};
      end
   end

   // Register writes; bit 6 of interface control is masked off
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         patternCtrl_reg <= `PATTERN_CTRL_RESET;
         rxIfCtrl_reg <= `RX_IF_CTRL_RESET;
      end else if (wrEn) begin
         if (addr == `PATTERN_CTRL_ADDR) begin
            patternCtrl_reg <= wrData;
         end else if (addr == `RX_IF_CTRL_ADDR) begin
            rxIfCtrl_reg <= wrData & `RX_IF_WRITE_MASK;
         end
      end
   end

   // Read data stands one cycle after the strobe; unmapped reads zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= 8'h00;
      end else if (rdEn) begin
         if (addr == `PATTERN_CTRL_ADDR) begin
            rdData <= patternCtrl_reg;
         end else if (addr == `RX_IF_CTRL_ADDR) begin
            rdData <= rxIfCtrl_reg & `RX_IF_WRITE_MASK;
         end else if (addr == `STATUS_ADDR) begin
            rdData <= {overrun_reg, 2'h0, slot};
         end else begin
            rdData <= 8'h00;
         end
      end else begin
         rdData <= 8'h00;
      end
   end

   // Bit counter within the 256-bit frame, realigned by frame sync
   always @* begin
      bitCount_next = bitCount_reg;
      if (linkRise) begin
         if (fsSync_reg[1]) begin
            bitCount_next = 8'h00;
         end else begin
            bitCount_next = bitCount_reg + 8'h01;
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bitCount_reg <= 8'h00;
      end else begin
         bitCount_reg <= bitCount_next;
      end
   end

   // Pattern generators run only while unframed generation is enabled
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prbs_reg <= `PRBS_SEED;
         qrts_reg <= `QRTS_SEED;
      end else if (linkRise && unframedActive) begin
         prbs_reg <= prbsStep(prbs_reg);
         qrts_reg <= {qrts_reg[18:0], qrts_reg[19] ^ qrts_reg[16]};
      end
   end

   // Long zero runs are forced to one in the quasi-random pattern
   assign patternBit = patternCtrl_reg[`PATTERN_TYPE_BIT] ?
      ((qrts_reg[13:0] == 14'h0000) ? 1'b1 : qrts_reg[19]) : prbs_reg[14];

   // Every slot and framing bit replaced, no frame alignment honoured
   assign rxMuxBit = (unframedActive && patternSwitch) ? patternBit : rxSync_reg[1];

   // Line output and receive bit, updated once per line bit
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txLineOut <= 1'b0;
         rxBit_reg <= 1'b0;
      end else if (linkRise) begin
         if (unframedActive && !patternSwitch) begin
            txLineOut <= patternBit;
         end else begin
            txLineOut <= txSync_reg[1];
         end
         rxBit_reg <= rxMuxBit;
      end
   end

   // Serial clock: continuous, or gapped over the overhead slot
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxSerialClock <= 1'b0;
      end else if (gappedEnable) begin
         rxSerialClock <= linkLevel & ~overhead;
      end else begin
         rxSerialClock <= linkLevel;
      end
   end

   // Channel clock: a clock on payload bits, or a data-valid level
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxTimeslotClock <= 1'b0;
      end else if (!fracEnable || highSpeed) begin
         rxTimeslotClock <= 1'b0;
      end else if (fracSelect) begin
         rxTimeslotClock <= ~overhead;
      end else begin
         rxTimeslotClock <= linkLevel & ~overhead;
      end
   end

   // Fractional data holds the payload bit, zero over the overhead slot
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fracData_reg <= 1'b0;
      end else if (linkRise) begin
         fracData_reg <= rxMuxBit & ~(bitCount_next[7:3] == `OVERHEAD_SLOT);
      end
   end

   assign serialIdBit = serialSlotBit(slot, slotBit);

   // Identifier pin function select
   always @* begin
      pins_next = slot;
      if (highSpeed) begin
         pins_next = {linkLevel, 3'h0, sigSync_reg[1]};
      end else if (fracEnable) begin
         pins_next[0] = sigSync_reg[1];
         pins_next[1] = fracData_reg;
         pins_next[2] = serialIdBit;
         pins_next[3] = ~bitCount_reg[7];
         pins_next[4] = linkLevel;
      end
   end

   // Pins registered so no decode glitch reaches the backplane
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timeslotIdentifierPins <= 5'h00;
      end else begin
         timeslotIdentifierPins <= pins_next;
      end
   end

   // Backplane drops a bit when the buffer is full; the loss is latched for software
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overrun_reg <= 1'b0;
      end else if (linkRise && !fifoInReady) begin
         overrun_reg <= 1'b1;
      end
   end

   assign rxAcceptReady = fifoInReady;

   // Receive bits buffered towards the backplane, pushed one cycle after each line bit
   reg pushPending_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pushPending_reg <= 1'b0;
      end else begin
         pushPending_reg <= linkRise;
      end
   end

   sample_fifo #(
      .WIDTH(1),
      .DEPTH(32),
      .AW(5)
   ) rxBuffer (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(pushPending_reg),
      .inReady(fifoInReady),
      .inData(rxBit_reg),
      .outValid(rxSerialValid),
      .outReady(backplaneReady),
      .outData(rxSerialData)
   );
endmodule
`default_nettype wire

// ---- hw/sample_fifo.v ----
// First-in first-out buffer with valid and ready on both sides
`default_nettype none
module sample_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk,
   input wire rst_n,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wrPtr_reg;
   reg [AW:0] rdPtr_reg;
   wire [AW:0] fill;
   wire push;
   wire pop;

   // Extra pointer bit tells full from empty
   assign fill = wrPtr_reg - rdPtr_reg;
   assign inReady = (fill != DEPTH[AW:0]);
   assign outValid = (fill != {(AW+1){1'b0}});
   assign push = inValid & inReady;
   assign pop = outValid & outReady;
   assign outData = mem[rdPtr_reg[AW-1:0]];

   // Storage written by index, no reset needed
   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg[AW-1:0]] <= inData;
      end
   end

   // Pointers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= {(AW+1){1'b0}};
         rdPtr_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- include/rx_backplane_map.vh ----
// Register map, field positions and constants of the receive backplane output block
`ifndef RX_BACKPLANE_MAP_VH
`define RX_BACKPLANE_MAP_VH

// Register offsets
`define PATTERN_CTRL_ADDR 12'h121
`define RX_IF_CTRL_ADDR 12'h122
`define STATUS_ADDR 12'h123

// Pattern control fields
`define UNFRAMED_BIT 0
`define PATTERN_SWITCH_BIT 3
`define PATTERN_TYPE_BIT 5
`define PATTERN_CTRL_RESET 8'h00

// Receive interface control fields
`define FRACTIONAL_CLOCK_SELECT_BIT 7
`define RESERVED_BIT 6
`define GAPPED_CLOCK_BIT 5
`define FRACTIONAL_ENABLE_BIT 4
`define MUX_ENABLE_BIT 2
`define RX_IF_CTRL_RESET 8'h00
`define RX_IF_WRITE_MASK 8'hBF

// Status fields
`define STATUS_OVERRUN_BIT 7

// Frame geometry: 32 slots of 8 bits
`define SLOT_BITS 3'h7
`define FRAME_LAST 8'hFF
`define OVERHEAD_SLOT 5'h00
`define SERIAL_ID_BITS 3'h5

// Pattern generator seeds
`define PRBS_SEED 15'h7FFF
`define QRTS_SEED 20'hFFFFF

`endif

// ---- verif/backplane_sink.sv ----
// Backplane receiver model collecting serial bits
`default_nettype none
module backplane_sink (
   input wire logic clk,
   input wire logic stall,
   input wire logic rxSerialData,
   input wire logic rxSerialValid,
   output logic backplaneReady
);
   logic got[$];
   // Slow side simply withholds ready
   assign backplaneReady = !stall;
   // Bit taken only on valid and ready together
   always @(posedge clk) begin
      if (rxSerialValid && backplaneReady)
         got.push_back(rxSerialData);
   end
endmodule
`default_nettype wire

// ---- verif/rx_backplane_output_config_sva.sv ----
// Assertions on the receive backplane output pins
`default_nettype none
module rx_backplane_output_config_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [7:0] rdData,
   input wire logic lineClockIn,
   input wire logic signalingIn,
   input wire logic rxSerialClock,
   input wire logic rxTimeslotClock,
   input wire logic [4:0] timeslotIdentifierPins
);
   logic [7:0] ctrlReg;
   wire hs = ctrlReg[2] || ctrlReg[1:0] != 2'h0;
   wire remap = ctrlReg[4] || hs;
   wire frBase = ctrlReg[4] && !hs;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Shadow of the control register, reserved bit never kept
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ctrlReg <= 8'h00;
      else if (wrEn && addr == 12'h122)
         ctrlReg <= wrData & 8'hBF;
   end
   // Overhead slot on the parallel pins while gapped
   sequence slotZero;
      ctrlReg[5:0] == 6'h20 && timeslotIdentifierPins == 5'h00;
   endsequence
   a_gap_in_overhead: assert property (slotZero [*8] ##1 slotZero |-> !$past(rxSerialClock))
      else $error("serial clock in overhead");
   a_clock_continuous: assert property (!ctrlReg[5] && $rose(lineClockIn) |-> ##[2:5] $rose(rxSerialClock))
      else $error("serial clock edge missing");
   a_pin4_clock: assert property (remap && $rose(lineClockIn) |-> ##[2:5] $rose(timeslotIdentifierPins[4]))
      else $error("pin4 clock missing");
   a_pin0_signal: assert property ((remap && $stable(signalingIn)) [*6] |-> timeslotIdentifierPins[0] == signalingIn)
      else $error("pin0 not signaling");
   a_fast_pins_low: assert property (hs [*3] |-> timeslotIdentifierPins[3:1] == 3'h0 && !rxTimeslotClock)
      else $error("fast mode pins wrong");
   a_base_no_chclk: assert property (!remap [*3] |-> !rxTimeslotClock)
      else $error("channel clock active");
   a_chclk_follows: assert property (frBase && !ctrlReg[7] && $rose(rxTimeslotClock) |-> $past(lineClockIn, 2))
      else $error("channel clock off line");
   a_chclk_enable: assert property (frBase && ctrlReg[7] && rxTimeslotClock && $fell(lineClockIn) |-> ##3 rxTimeslotClock)
      else $error("enable dropped");
   a_reserved_zero: assert property (rdEn && addr == 12'h122 |=> !rdData[6])
      else $error("reserved bit set");
endmodule
bind rx_backplane_output_config rx_backplane_output_config_sva u_sva (.clk(clk), .rst_n(rst_n), .addr(addr),
   .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .lineClockIn(lineClockIn), .signalingIn(signalingIn),
   .rxSerialClock(rxSerialClock), .rxTimeslotClock(rxTimeslotClock), .timeslotIdentifierPins(timeslotIdentifierPins));
`default_nettype wire

// ---- verif/rx_backplane_output_config_tb.sv ----
// Bench for the receive backplane output block
`default_nettype none
module rx_backplane_output_config_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, wrEn = 0, rdEn = 0, lineClockIn = 0, frameSyncIn = 0;
   logic rxDataIn = 0, txDataIn = 0, signalingIn = 0, stall = 0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wrData = 8'h00, v;
   wire [7:0] rdData;
   wire [4:0] pins;
   wire txLineOut, rxSerialClock, rxTimeslotClock, rxSerialData, rxSerialValid, backplaneReady, rxAcceptReady;
   logic cap[$];
   int miscompares = 0, compares = 0, cycles = 0, hi = 0, h, sc = 0, g;
   rx_backplane_output_config u_rx_backplane_output_config (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .lineClockIn(lineClockIn),
      .frameSyncIn(frameSyncIn), .rxDataIn(rxDataIn), .txDataIn(txDataIn), .signalingIn(signalingIn),
      .txLineOut(txLineOut), .rxSerialClock(rxSerialClock), .rxTimeslotClock(rxTimeslotClock),
      .timeslotIdentifierPins(pins), .rxSerialData(rxSerialData), .rxSerialValid(rxSerialValid),
      .backplaneReady(backplaneReady), .rxAcceptReady(rxAcceptReady));
   backplane_sink u_backplane_sink (.clk(clk), .stall(stall), .rxSerialData(rxSerialData),
      .rxSerialValid(rxSerialValid), .backplaneReady(backplaneReady));
   initial begin
      forever #50 clk = ~clk;
   end
   // Hang guard and channel clock high time
   always @(posedge clk) begin
      cycles++;
      hi += rxTimeslotClock;
      sc += rxSerialClock;
      if (cycles == 12000) begin
         miscompares++;
         results();
      end
   end
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1;
      @(posedge clk);
      wrEn <= 0;
   endtask
   task rd(input logic [11:0] a);
      @(posedge clk);
      addr <= a;
      rdEn <= 1;
      @(posedge clk);
      rdEn <= 0;
      @(negedge clk);
      v = rdData;
   endtask
   // Link clock of eight system clocks, driven on rising edges; data moves on its fall
   task bits(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         lineClockIn <= 1;
         repeat (4) @(posedge clk);
         lineClockIn <= 0;
         txDataIn <= i[1];
         rxDataIn <= i[2];
         frameSyncIn <= 0;
         repeat (3) @(posedge clk);
         cap.push_back(txLineOut);
      end
   endtask
   // Quasi-random stream must toggle and must not obey the PRBS15 recurrence
   task qrts();
      int ones, odd;
      ones = 0;
      odd = 0;
      for (int k = 20; k < cap.size(); k++) begin
         ones += cap[k];
         odd += cap[k] ^ cap[k - 14] ^ cap[k - 15];
      end
      chk("qrts mixed", 8'(ones > 0 && ones < cap.size() - 20), 1);
      chk("qrts not prbs", 8'(odd > 0), 1);
   endtask
   // Phase free: each bit is the XOR of those 14 and 15 back
   task prbs(input logic q[$]);
      for (int k = 20; k < q.size(); k++)
         chk("prbs bit", q[k], q[k - 14] ^ q[k - 15]);
   endtask
   task follows();
      for (int k = 2; k < cap.size(); k++)
         chk("line bit", cap[k], 8'((k - 1) >> 1 & 1));
   endtask
   task t_regs();
      rd(12'h121);
      chk("pattern reset", v, 8'h00);
      wr(12'h122, 8'hFF);
      rd(12'h122);
      chk("reserved bit", v, 8'hBF);
      wr(12'h121, 8'h29);
      rd(12'h121);
      chk("pattern rw", v, 8'h29);
      wr(12'h3FF, 8'hFF);
      rd(12'h3FF);
      chk("unmapped", v, 8'h00);
      $display("test regs done");
   endtask
   task t_pattern();
      wr(12'h121, 8'h00);
      cap.delete();
      bits(40);
      prbs(cap);
      wr(12'h121, 8'h08);
      cap.delete();
      u_backplane_sink.got.delete();
      bits(40);
      prbs(u_backplane_sink.got);
      follows();
      wr(12'h121, 8'h01);
      cap.delete();
      bits(20);
      follows();
      wr(12'h121, 8'h20);
      cap.delete();
      bits(60);
      qrts();
      $display("test pattern done");
   endtask
   task t_slots();
      wr(12'h122, 8'h00);
      bits(38);
      rd(12'h123);
      chk("slot pins", pins, v & 8'h1F);
      wr(12'h122, 8'h10);
      repeat (3) @(posedge clk);
      chk("8k pin", pins[3], v[4:0] < 16);
      chk("fraction pin", pins[1], v[4:0] != 0);
      signalingIn <= 1;
      bits(4);
      wr(12'h122, 8'h01);
      repeat (3) @(posedge clk);
      chk("fast pins", pins, 8'h01);
      $display("test slots done");
   endtask
   task t_chclk();
      wr(12'h122, 8'h10);
      frameSyncIn <= 1;
      h = hi;
      g = sc;
      bits(256);
      chk("chclk sel0", hi - h inside {[980:1004]}, 1);
      chk("serial clock full", sc - g inside {[1012:1036]}, 1);
      wr(12'h122, 8'h90);
      h = hi;
      bits(256);
      chk("chclk sel1", hi - h inside {[1960:2010]}, 1);
      wr(12'h122, 8'h20);
      g = sc;
      bits(256);
      chk("serial clock gapped", sc - g inside {[980:1004]}, 1);
      $display("test channel clock done");
   endtask
   task t_fifo();
      wr(12'h122, 8'h00);
      u_backplane_sink.got.delete();
      stall <= 1;
      bits(36);
      chk("fifo full", rxAcceptReady, 0);
      rd(12'h123);
      chk("overrun", v[7], 1);
      stall <= 0;
      repeat (40) @(posedge clk);
      chk("drained", rxSerialValid, 0);
      chk("kept bits", 8'(u_backplane_sink.got.size()), 32);
      $display("test fifo done");
   endtask
   task results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      t_regs();
      t_pattern();
      t_slots();
      t_chclk();
      t_fifo();
      results();
   end
endmodule
`default_nettype wire
